// *** design/urb_defines.svh ***
// Register offsets, field positions and timing counts for the UART buffer block
`ifndef URB_DEFINES_SVH
`define URB_DEFINES_SVH
`define URB_OFF_RXBUF 4'h0
`define URB_OFF_TXBUF 4'h1
`define URB_OFF_ICHG 4'h2
`define URB_OFF_AUX 4'h3
`define URB_OFF_CMD 4'h4
`define URB_OFF_MODE 4'h5
`define URB_OFF_STAT 4'h6
`define URB_OFF_ISR 4'h7
`define URB_OFF_IMR 4'h8
`define URB_ICHG_COS 4
`define URB_ICHG_CTS 0
`define URB_AUX_IEC 0
`define URB_ISR_TRANSMITTER_READY_FLAG 0
`define URB_ISR_RXRDY 1
`define URB_ISR_COS 7
`define URB_STAT_RXRDY 0
`define URB_STAT_FFULL 1
`define URB_STAT_TRANSMITTER_READY_FLAG 2
`define URB_STAT_TXEMP 3
`define URB_STAT_RXEN 4
`define URB_STAT_TXEN 5
`define URB_MODE_PM_LO 3
`define URB_MODE_LOOP 6
`define URB_RC_NONE 2'h0
`define URB_RC_EN 2'h1
`define URB_RC_DIS 2'h2
`define URB_TC_EN 2'h1
`define URB_TC_DIS 2'h2
`define URB_PM_MULTI 2'h3
`define URB_FIFO_DEPTH 3
`define URB_FILT_NS 25000
`define URB_CLK_NS 25
`define URB_FILT_CYC ((`URB_FILT_NS + `URB_CLK_NS - 1) / `URB_CLK_NS)
`define URB_SCLK_DIV 16
`define URB_START_CYC (2 * `URB_SCLK_DIV)
`define URB_BITCYC 16
`endif

// *** design/urb_pkg.sv ***
// Types shared by the UART buffer block
`default_nettype none
package urb_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} urb_rx_e;
    typedef struct packed {
        logic [3:0] addr;
        logic rd;
        logic wr;
        logic [31:0] wdata;
    } urb_bus_s;
endpackage : urb_pkg
`default_nettype wire

// *** design/urb_uart_buf.sv ***
// UART receive FIFO, transmit buffers and CTS change detection
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`include "urb_defines.svh"
`default_nettype none
module urb_uart_buf
    import urb_pkg::*;
#(
    parameter int FILT_CYC = `URB_FILT_CYC,
    parameter int BIT_CYC = `URB_BITCYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input wire logic rxd,
    output logic txd,
    input wire logic ctsN,
    output logic irq
);
    typedef struct packed {
        logic [7:0] fifo0;
        logic [7:0] fifo1;
        logic [7:0] fifo2;
        logic [1:0] count;
        urb_rx_e rxState;
        logic [3:0] rxBits;
        logic [15:0] rxTimer;
        logic [7:0] rxShift;
        logic rxEn;
        logic txEn;
        logic [7:0] txHold;
        logic txReady;
        logic [9:0] txShift;
        logic [3:0] txBits;
        logic [15:0] txTimer;
        logic txBusy;
        logic [7:0] mode;
        logic iec;
        logic ctsLevel;
        logic ctsCand;
        logic [15:0] filtCnt;
        logic [7:0] startCnt;
        logic tracking;
        logic line_change_flag;
        logic [7:0] isrSticky;
        logic [7:0] imr;
        logic ack;
        logic [31:0] rdata;
    } urb_state_s;

    urb_state_s state_reg, state_next;
    urb_bus_s bus;
    logic rxRun, rxDone, wrHit, rdHit, multi, loopRx, cosSet;
    logic [7:0] isrView;

    assign bus = '{addr: avsAddress, rd: avsRead, wr: avsWrite,
                   wdata: avsWriteData};
    // Writes land on the edge that ends the wait, as the master expects
    assign wrHit = bus.wr && state_reg.ack;
    assign rdHit = bus.rd && !state_reg.ack;
    assign multi = state_reg.mode[`URB_MODE_PM_LO +: 2] == `URB_PM_MULTI;
    // Loop-back feeds the receiver from the transmitter
    assign loopRx = state_reg.mode[`URB_MODE_LOOP] ? txd : rxd;
    assign rxRun = state_reg.rxEn || multi
        || state_reg.mode[`URB_MODE_LOOP];
    assign isrView = {state_reg.isrSticky[7:2], state_reg.count != 2'h0,
                      state_reg.txReady};
    // One wait cycle per access keeps read side effects single-shot
    assign avsWaitRequest = (bus.rd || bus.wr) && !state_reg.ack;
    assign avsReadData = state_reg.rdata;
    assign irq = |(isrView & state_reg.imr);
    assign txd = state_reg.txShift[0];
    assign rxDone = state_reg.rxState == RX_SHIFT
        && state_reg.rxTimer == 16'h0 && state_reg.rxBits == 4'h9;

    always_comb begin
        state_next = state_reg;
        cosSet = 1'b0;
        state_next.ack = (bus.rd || bus.wr) && !state_reg.ack;
        // Receiver shifter, sampling mid-bit
        if (!rxRun) begin
            state_next.rxState = RX_IDLE;
        end else begin
            unique case (state_reg.rxState)
                RX_IDLE: begin
                    if (!loopRx) begin
                        state_next.rxState = RX_SHIFT;
                        state_next.rxBits = 4'h0;
                        state_next.rxTimer = 16'(BIT_CYC / 2);
                    end
                end
                RX_SHIFT: begin
                    if (state_reg.rxTimer != 16'h0) begin
                        state_next.rxTimer = state_reg.rxTimer - 16'h1;
                    end else begin
                        state_next.rxTimer = 16'(BIT_CYC - 1);
                        state_next.rxBits = state_reg.rxBits + 4'h1;
                        if (state_reg.rxBits >= 4'h1
                                && state_reg.rxBits <= 4'h8) begin
                            state_next.rxShift = {loopRx,
                                                  state_reg.rxShift[7:1]};
                        end
                        if (rxDone) begin
                            state_next.rxState = RX_IDLE;
                        end
                    end
                end
            endcase
        end
        // Queue pop on read of the receive buffer
        if (rdHit && bus.addr == `URB_OFF_RXBUF
                && state_reg.count != 2'h0) begin
            state_next.fifo0 = state_reg.fifo1;
            state_next.fifo1 = state_reg.fifo2;
            state_next.count = state_next.count - 2'h1;
        end
        // Tail push; a full queue drops the new character
        if (rxDone && state_next.count != 2'(`URB_FIFO_DEPTH)) begin
            unique case (state_next.count)
                2'h0: state_next.fifo0 = state_reg.rxShift;
                2'h1: state_next.fifo1 = state_reg.rxShift;
                default: state_next.fifo2 = state_reg.rxShift;
            endcase
            state_next.count = state_next.count + 2'h1;
        end
        // Transmit shifter
        if (state_reg.txBusy) begin
            if (state_reg.txTimer != 16'h0) begin
                state_next.txTimer = state_reg.txTimer - 16'h1;
            end else if (state_reg.txBits == 4'h0) begin
                state_next.txBusy = 1'b0;
            end else begin
                state_next.txTimer = 16'(BIT_CYC - 1);
                state_next.txShift = {1'b1, state_reg.txShift[9:1]};
                state_next.txBits = state_reg.txBits - 4'h1;
            end
        end else if (!state_reg.txReady && state_reg.txEn) begin
            state_next.txShift = {1'b1, state_reg.txHold, 1'b0};
            state_next.txBits = 4'h9;
            state_next.txTimer = 16'(BIT_CYC - 1);
            state_next.txBusy = 1'b1;
            state_next.txReady = 1'b1;
        end
        // CTS filter and start-up tracking
        if (!state_reg.tracking) begin
            state_next.startCnt = state_reg.startCnt + 8'h1;
            if (state_reg.startCnt == 8'(`URB_START_CYC - 1)) begin
                state_next.tracking = 1'b1;
                state_next.ctsLevel = ctsN;
                state_next.ctsCand = ctsN;
                if (!ctsN) begin
                    state_next.line_change_flag = 1'b1;
                    cosSet = 1'b1;
                    if (state_reg.iec) begin
                        state_next.isrSticky[`URB_ISR_COS] = 1'b1;
                    end
                end
            end
        end else if (ctsN == state_reg.ctsLevel) begin
            state_next.filtCnt = 16'h0;
        end else if (state_reg.filtCnt == 16'(FILT_CYC - 1)) begin
            state_next.filtCnt = 16'h0;
            state_next.ctsLevel = ctsN;
            state_next.line_change_flag = 1'b1;
            cosSet = 1'b1;
            if (state_reg.iec) begin
                state_next.isrSticky[`URB_ISR_COS] = 1'b1;
            end
        end else begin
            state_next.filtCnt = state_reg.filtCnt + 16'h1;
        end
        // Register writes
        if (wrHit) begin
            unique case (bus.addr)
                `URB_OFF_TXBUF: begin
                    if (state_reg.txReady && state_reg.txEn) begin
                        state_next.txHold = bus.wdata[7:0];
                        state_next.txReady = 1'b0;
                    end
                end
                `URB_OFF_AUX: state_next.iec = bus.wdata[`URB_AUX_IEC];
                `URB_OFF_CMD: begin
                    // Code 00 and 11 leave the receiver as is
                    if (bus.wdata[1:0] == `URB_RC_EN && !multi
                            && !state_reg.rxEn) begin
                        state_next.rxEn = 1'b1;
                        state_next.rxState = RX_IDLE;
                    end else if (bus.wdata[1:0] == `URB_RC_DIS) begin
                        state_next.rxEn = 1'b0;
                    end
                    if (bus.wdata[3:2] == `URB_TC_EN && !state_reg.txEn) begin
                        state_next.txEn = 1'b1;
                        state_next.txReady = 1'b1;
                    end else if (bus.wdata[3:2] == `URB_TC_DIS) begin
                        state_next.txEn = 1'b0;
                    end
                end
                `URB_OFF_MODE: state_next.mode = bus.wdata[7:0];
                `URB_OFF_ISR: begin
                    // Write one to clear; a same-cycle event still sets
                    state_next.isrSticky = state_reg.isrSticky
                        & ~bus.wdata[7:0];
                    if (cosSet && state_reg.iec) begin
                        state_next.isrSticky[`URB_ISR_COS] = 1'b1;
                    end
                end
                `URB_OFF_IMR: state_next.imr = bus.wdata[7:0];
                default: ;
            endcase
        end
        // Register reads
        state_next.rdata = 32'h0;
        if (rdHit) begin
            unique case (bus.addr)
                `URB_OFF_RXBUF: state_next.rdata[7:0] = state_reg.fifo0;
                `URB_OFF_ICHG: begin
                    state_next.rdata[`URB_ICHG_COS] = state_reg.line_change_flag;
                    state_next.rdata[`URB_ICHG_CTS] = state_reg.ctsLevel;
                    // Clear only if no new change arrives this cycle
                    if (!cosSet) begin
                        state_next.line_change_flag = 1'b0;
                        state_next.isrSticky[`URB_ISR_COS] = 1'b0;
                    end
                end
                `URB_OFF_AUX: state_next.rdata[0] = state_reg.iec;
                `URB_OFF_MODE: state_next.rdata[7:0] = state_reg.mode;
                `URB_OFF_STAT: begin
                    state_next.rdata[`URB_STAT_RXRDY] = state_reg.count != 2'h0;
                    state_next.rdata[`URB_STAT_FFULL] =
                        state_reg.count == 2'(`URB_FIFO_DEPTH);
                    state_next.rdata[`URB_STAT_TRANSMITTER_READY_FLAG] = state_reg.txReady;
                    state_next.rdata[`URB_STAT_TXEMP] =
                        state_reg.txReady && !state_reg.txBusy;
                    state_next.rdata[`URB_STAT_RXEN] = state_reg.rxEn;
                    state_next.rdata[`URB_STAT_TXEN] = state_reg.txEn;
                end
                `URB_OFF_ISR: state_next.rdata[7:0] = isrView;
                `URB_OFF_IMR: state_next.rdata[7:0] = state_reg.imr;
                default: ;
            endcase
        end
        // Follows the new enable, so enabling does not send a stale byte
        if (!state_next.txEn) begin
            state_next.txReady = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= '0;
            state_reg.txShift <= 10'h3ff;
            state_reg.ctsLevel <= 1'b1;
            state_reg.ctsCand <= 1'b1;
            state_reg.rxState <= RX_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    logic [15:0] ctsLowRun;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctsLowRun <= 16'h0;
        end else if (ctsN != state_reg.ctsLevel) begin
            ctsLowRun <= ctsLowRun + 16'h1;
        end else begin
            ctsLowRun <= 16'h0;
        end
    end

    AST_IRQ_MASK: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg.imr == 8'h0) |-> !irq)
        else $error("Interrupt raised with all masks clear");
    AST_TX_ACCEPT: assert property (@(posedge clk) disable iff (!resetn)
        (wrHit && bus.addr == `URB_OFF_TXBUF && state_reg.txReady
         && state_reg.txEn) |=> (state_reg.txHold == $past(bus.wdata[7:0])))
        else $error("Transmit write not stored");
    AST_TX_BLOCK: assert property (@(posedge clk) disable iff (!resetn)
        (wrHit && bus.addr == `URB_OFF_TXBUF && !state_reg.txReady)
        |=> $stable(state_reg.txHold))
        else $error("Transmit buffer changed while not ready");
    AST_TX_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
        (wrHit && bus.addr == `URB_OFF_TXBUF && state_reg.txReady
         && state_reg.txEn && !state_reg.txBusy) |=> !state_reg.txReady)
        else $error("Ready not cleared by write");
    AST_TX_RELOAD: assert property (@(posedge clk) disable iff (!resetn)
        (!state_reg.txBusy && !state_reg.txReady && state_reg.txEn)
        |=> (state_reg.txBusy && state_reg.txReady))
        else $error("Shifter did not take held character");
    AST_RX_DISABLE: assert property (@(posedge clk) disable iff (!resetn)
        (wrHit && bus.addr == `URB_OFF_CMD && bus.wdata[1:0] == `URB_RC_DIS
         && !multi && !state_reg.mode[`URB_MODE_LOOP])
        |=> ##1 (state_reg.rxState == RX_IDLE))
        else $error("Receiver kept running after disable");
    AST_RX_ENABLE: assert property (@(posedge clk) disable iff (!resetn)
        (wrHit && bus.addr == `URB_OFF_CMD && bus.wdata[1:0] == `URB_RC_EN
         && !multi) |=> state_reg.rxEn)
        else $error("Receiver not enabled");
    AST_RX_NOP: assert property (@(posedge clk) disable iff (!resetn)
        (wrHit && bus.addr == `URB_OFF_CMD && bus.wdata[1:0] == `URB_RC_NONE)
        |=> $stable(state_reg.rxEn))
        else $error("No-action command changed receiver");
    AST_COS_FILTER: assert property (@(posedge clk) disable iff (!resetn)
        $rose(state_reg.line_change_flag) && state_reg.tracking && $past(state_reg.tracking)
        |-> $past(ctsLowRun) == 16'(FILT_CYC - 1))
        else $error("Change flag set without filtered transition");
    AST_COS_GATE: assert property (@(posedge clk) disable iff (!resetn)
        !state_reg.iec && $stable(state_reg.iec)
        && !$past(state_reg.isrSticky[`URB_ISR_COS])
        |-> !state_reg.isrSticky[`URB_ISR_COS])
        else $error("Change status set while gated off");
    AST_FIFO_LIMIT: assert property (@(posedge clk) disable iff (!resetn)
        state_reg.count <= 2'(`URB_FIFO_DEPTH))
        else $error("Queue count beyond depth");

    COV_RX_FULL: cover property (@(posedge clk) disable iff (!resetn)
        state_reg.count == 2'(`URB_FIFO_DEPTH));
    COV_TX_RELOAD: cover property (@(posedge clk) disable iff (!resetn)
        state_reg.txBusy && !state_reg.txReady);
    COV_COS_IRQ: cover property (@(posedge clk) disable iff (!resetn)
        state_reg.isrSticky[`URB_ISR_COS] && irq);
endmodule : urb_uart_buf
`default_nettype wire

// *** verification/tb_urb_uart_buf.sv ***
// Self-checking bench for the UART buffer block
`include "urb_defines.svh"
`default_nettype none
module tb_urb_uart_buf;
    timeunit 1ns;
    timeprecision 1ps;
    // Short counts keep the run brief
    localparam int FC = 4;
    localparam int BC = 4;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [31:0] avsReadData;
    logic avsWaitRequest;
    logic rxd;
    logic txd;
    logic ctsN = 1'b0;
    logic irq;
    logic [31:0] q;
    logic [7:0] rxVals[4] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4};
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;

    always #12.5 clk = ~clk;

    urb_uart_buf #(.FILT_CYC(FC), .BIT_CYC(BC)) DUT (
        .clk(clk), .resetn(resetn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .rxd(rxd), .txd(txd),
        .ctsN(ctsN), .irq(irq));

    urb_serial_peer #(.BIT_CYC(BC)) peer (
        .clk(clk), .rxd(rxd), .txd(txd));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] got);
        n_tests++;
        if (got !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, got);
            errors++;
        end
    endtask : chk

    // Entered just after a rising edge; an idle edge keeps strobes apart
    task automatic bus(input logic [3:0] a, input logic w,
                       input logic [7:0] d);
        int n;
        n = 0;
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= ~w;
        avsWriteData <= {24'h0, d};
        @(posedge clk);
        while (avsWaitRequest !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) chk("waitrequest", 32'h0, 32'h1);
        q = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [3:0] a, input string nm,
                      input logic [7:0] m, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        chk(nm, {24'h0, e}, q & {24'h0, m});
    endtask : rd

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            chk("timeout", 32'h0, 32'h1);
            end_sim();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // Gate and mask set before CTS tracking starts
        wr(`URB_OFF_AUX, 8'h01);
        wr(`URB_OFF_IMR, 8'h80);
        rd(`URB_OFF_AUX, "aux", 8'hff, 8'h01);
        wt(40);
        chk("irq start", 32'h1, {31'h0, irq});
        rd(`URB_OFF_ICHG, "ichg", 8'hff, 8'h10);
        chk("irq rdclr", 32'h0, {31'h0, irq});
        rd(`URB_OFF_ISR, "isr cos", 8'h80, 8'h00);
        ctsN <= 1'b1;
        wt(FC + 12);
        chk("irq neg", 32'h1, {31'h0, irq});
        rd(`URB_OFF_ICHG, "ichg", 8'hff, 8'h11);
        ctsN <= 1'b0;
        wt(FC - 2);
        ctsN <= 1'b1;
        wt(FC + 12);
        rd(`URB_OFF_ICHG, "glitch", 8'h10, 8'h00);
        wr(`URB_OFF_IMR, 8'h00);
        ctsN <= 1'b0;
        wt(FC + 12);
        chk("irq mask", 32'h0, {31'h0, irq});
        rd(`URB_OFF_ISR, "isr cos", 8'h80, 8'h80);
        rd(`URB_OFF_ICHG, "ichg", 8'hff, 8'h10);
        wr(`URB_OFF_AUX, 8'h00);
        wr(`URB_OFF_IMR, 8'h80);
        ctsN <= 1'b1;
        wt(FC + 12);
        chk("irq gate", 32'h0, {31'h0, irq});
        rd(`URB_OFF_ISR, "isr cos", 8'h80, 8'h00);
        rd(`URB_OFF_ICHG, "ichg", 8'hff, 8'h11);
        $display("test cts done");
        // Receiver codes used are 00, 01 and 10 only
        peer.send_char(8'h77, 8);
        rd(`URB_OFF_STAT, "stat off", 8'h11, 8'h00);
        wr(`URB_OFF_CMD, 8'h01);
        rd(`URB_OFF_STAT, "rxen", 8'h10, 8'h10);
        wr(`URB_OFF_CMD, 8'h00);
        rd(`URB_OFF_STAT, "rxen", 8'h10, 8'h10);
        // Enable again mid-character must not restart the shifter
        fork
            peer.send_char(rxVals[0], 8);
            begin
                wt(14);
                wr(`URB_OFF_CMD, 8'h01);
            end
        join
        for (int i = 1; i < 4; i++) begin
            peer.send_char(rxVals[i], 8);
        end
        rd(`URB_OFF_STAT, "full", 8'h03, 8'h03);
        for (int i = 0; i < 3; i++) begin
            rd(`URB_OFF_RXBUF, "rxbuf", 8'hff, rxVals[i]);
        end
        rd(`URB_OFF_STAT, "empty", 8'h03, 8'h00);
        peer.send_char(8'h55, 8);
        fork
            peer.send_char(8'h5a, 8);
            begin
                wt(14);
                wr(`URB_OFF_CMD, 8'h02);
            end
        join
        wt(8);
        rd(`URB_OFF_STAT, "dis", 8'h13, 8'h01);
        rd(`URB_OFF_AUX, "aux", 8'hff, 8'h00);
        rd(`URB_OFF_RXBUF, "rxbuf", 8'hff, 8'h55);
        rd(`URB_OFF_STAT, "lost", 8'h01, 8'h00);
        wr(`URB_OFF_CMD, 8'h02);
        rd(`URB_OFF_STAT, "rxen", 8'h10, 8'h00);
        wr(`URB_OFF_MODE, 8'h18);
        peer.send_char(8'h66, 8);
        rd(`URB_OFF_STAT, "multi", 8'h01, 8'h01);
        rd(`URB_OFF_RXBUF, "rxbuf", 8'hff, 8'h66);
        wr(`URB_OFF_MODE, 8'h00);
        rd(4'hf, "unmapped", 8'hff, 8'h00);
        $display("test receiver done");
        wr(`URB_OFF_TXBUF, 8'h11);
        wt(60);
        chk("tx off", 32'h0, peer.gotQ.size());
        wr(`URB_OFF_CMD, 8'h04);
        rd(`URB_OFF_STAT, "transmitter_ready_flag", 8'h0c, 8'h0c);
        wr(`URB_OFF_TXBUF, 8'ha5);
        wr(`URB_OFF_TXBUF, 8'h3c);
        rd(`URB_OFF_STAT, "transmitter_ready_flag", 8'h04, 8'h00);
        wr(`URB_OFF_TXBUF, 8'h99);
        wt(100);
        rd(`URB_OFF_STAT, "transmitter_ready_flag", 8'h04, 8'h04);
        wr(`URB_OFF_IMR, 8'h01);
        chk("irq tx", 32'h1, {31'h0, irq});
        wr(`URB_OFF_IMR, 8'h00);
        wt(60);
        chk("tx count", 32'h2, peer.gotQ.size());
        chk("tx 0", 32'ha5, {24'h0, peer.gotQ[0]});
        chk("tx 1", 32'h3c, {24'h0, peer.gotQ[1]});
        // Loop-back feeds the disabled receiver from the send line
        wr(`URB_OFF_MODE, 8'h40);
        wr(`URB_OFF_TXBUF, 8'h4b);
        wt(60);
        rd(`URB_OFF_RXBUF, "loop", 8'hff, 8'h4b);
        rd(`URB_OFF_STAT, "loop rxen", 8'h10, 8'h00);
        chk("tx 2", 32'h4b, {24'h0, peer.gotQ[2]});
        wr(`URB_OFF_MODE, 8'h00);
        $display("test transmit done");
        end_sim();
    end
endmodule : tb_urb_uart_buf
`default_nettype wire

// *** verification/urb_serial_peer.sv ***
// Remote serial device model: drives the receive line, decodes the send line
`default_nettype none
module urb_serial_peer #(
    parameter int BIT_CYC = 4
) (
    input wire logic clk,
    output logic rxd,
    input wire logic txd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] gotQ[$];
    logic [7:0] sh;
    initial rxd = 1'b1;
    // Start bit, nBits data bits LSB first, rest of frame idle high
    task automatic send_char(input logic [7:0] b, input int nBits);
        rxd <= 1'b0;
        repeat (BIT_CYC) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rxd <= (i < nBits) ? b[i] : 1'b1;
            repeat (BIT_CYC) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (2 * BIT_CYC) @(posedge clk);
    endtask : send_char
    // Mid-bit sampling; frames without a stop bit are dropped
    initial begin
        forever begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                sh[i] = txd;
            end
            repeat (BIT_CYC) @(posedge clk);
            if (txd === 1'b1) gotQ.push_back(sh);
        end
    end
endmodule : urb_serial_peer
`default_nettype wire
